/* rtl/dsp_regs.sv */
// design identification, status, reset control and throughput counters
`timescale 1ns/1ps
module dsp_regs
   import dsp_pkg::*;
#(
   parameter int WINDOW_CYCLES = dsp_pkg::WINDOW_CYC,
   parameter int BEAT_BYTES    = 8
) (
   // clock and reset
   input  wire logic                     CORE_CLK,
   input  wire logic                     RSTN,
   // register access port
   input  wire logic [dsp_pkg::ADDR_W-1:0] REG_ADDR,
   input  wire logic                     REG_WR,
   input  wire logic                     REG_RD,
   input  wire logic [31:0]              REG_WDATA,
   output logic      [31:0]              REG_RDATA,
   output logic                          REG_RVALID,
   // status inputs from the pins of other blocks
   input  wire logic                     CALIB_DONE,
   input  wire logic [dsp_pkg::NUM_PORTS-1:0] PORT_BUFFER_EMPTY_FLAGS,
   // stream activity, same clock
   input  wire logic                     TX_BEAT,
   input  wire logic [7:0]               TX_BEAT_BYTES,
   input  wire logic                     RX_BEAT,
   input  wire logic [7:0]               RX_BEAT_BYTES,
   // reset out to interconnect and memory interface
   output logic                          INTERCONNECT_MEMIF_RESET_N
);
   import dsp_pkg::*;

   // refuse a window too short to wrap or a beat size the adder cannot take
   if (WINDOW_CYCLES < 2 || BEAT_BYTES < 1 || BEAT_BYTES > 255) begin
      $error("dsp_regs: bad parameter");
   end

   //////////////////////////////////////////////////////////////////////
   // state, one group per function
   // pin synchronisers and the status flags they feed
   logic [2:0]           calib_sync_ff,  nxt_calib_sync;
   logic [NUM_PORTS-1:0] empty_sync0_ff, nxt_empty_sync0;
   logic [NUM_PORTS-1:0] empty_sync1_ff, nxt_empty_sync1;
   logic [NUM_PORTS-1:0] empty_sync2_ff, nxt_empty_sync2;
   logic                 calib_ff,       nxt_calib;
   logic [NUM_PORTS-1:0] empty_ff,       nxt_empty;
   // reset control out
   logic                 rst_n_ff,       nxt_rst_n;
   logic [3:0]           hold_cnt_ff,    nxt_hold_cnt;
   logic                 clear_write;
   // throughput window and counters
   logic [31:0]          win_cnt_ff,     nxt_win_cnt;
   logic [31:0]          tx_acc_ff,      nxt_tx_acc;
   logic [31:0]          rx_acc_ff,      nxt_rx_acc;
   logic [29:0]          tx_pub_ff,      nxt_tx_pub;
   logic [29:0]          rx_pub_ff,      nxt_rx_pub;
   logic [1:0]           samples_ff,     nxt_samples;
   logic                 window_end;
   // read port
   logic [31:0]          rdata_ff,       nxt_rdata;
   logic                 rvalid_ff,      nxt_rvalid;

   //////////////////////////////////////////////////////////////////////
   // helpers
   // saturating add so a stuck stream cannot wrap the total
   function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [7:0] b);
      logic [32:0] s;
      s = {1'b0, a} + {25'h0000000, b};
      sat_add = s[32] ? 32'hFFFFFFFF : s[31:0];
   endfunction

   // a synchronised level counts only once the last two stages agree
   function automatic logic settle(input logic newer, input logic older, input logic held);
      settle = (newer == older) ? newer : held;
   endfunction

   //////////////////////////////////////////////////////////////////////
   // status inputs: three stages, then debounce
   // costs up to four cycles of latency, but one glitch never reaches software
   always_comb begin
      nxt_calib_sync  = {calib_sync_ff[1:0], CALIB_DONE};
      nxt_empty_sync0 = PORT_BUFFER_EMPTY_FLAGS;
      nxt_empty_sync1 = empty_sync0_ff;
      nxt_empty_sync2 = empty_sync1_ff;
      // (RULE7) calibration flag, debounced
      nxt_calib = settle(calib_sync_ff[1], calib_sync_ff[2], calib_ff);
      // (RULE9) empty flags per port
      for (int i = 0; i < NUM_PORTS; i++) begin
         nxt_empty[i] = settle(empty_sync1_ff[i], empty_sync2_ff[i], empty_ff[i]);
      end
   end

   // (RULE3) defaults on reset
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         calib_sync_ff  <= 3'h0;
         empty_sync0_ff <= EMPTY_RESET;
         empty_sync1_ff <= EMPTY_RESET;
         empty_sync2_ff <= EMPTY_RESET;
         calib_ff       <= 1'b0;
         empty_ff       <= EMPTY_RESET;
      end else begin
         calib_sync_ff  <= nxt_calib_sync;
         empty_sync0_ff <= nxt_empty_sync0;
         empty_sync1_ff <= nxt_empty_sync1;
         empty_sync2_ff <= nxt_empty_sync2;
         calib_ff       <= nxt_calib;
         empty_ff       <= nxt_empty;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // reset control out
   always_comb begin
      // (RULE8) a write of zero to the reset bit starts or restarts the hold
      clear_write  = REG_WR && (REG_ADDR == OFS_STATUS) && !REG_WDATA[STS_RESET_BIT];
      nxt_rst_n    = rst_n_ff;
      nxt_hold_cnt = hold_cnt_ff;
      if (clear_write) begin
         nxt_rst_n    = 1'b0;
         nxt_hold_cnt = 4'(RESET_HOLD_CYC - 1);
      end else if (!rst_n_ff) begin
         // (RULE8) self-restoring after the hold count
         if (hold_cnt_ff == 4'h0) begin
            nxt_rst_n = 1'b1;
         end else begin
            nxt_hold_cnt = hold_cnt_ff - 4'h1;
         end
      end
   end

   // (RULE3) reset out released after reset
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_n_ff    <= 1'b1;
         hold_cnt_ff <= 4'h0;
      end else begin
         rst_n_ff    <= nxt_rst_n;
         hold_cnt_ff <= nxt_hold_cnt;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // throughput window and counters
   // limitation: a total above 4 GB in one window sticks at all ones
   always_comb begin
      // (RULE13) one-second window, publish and restart
      window_end  = (win_cnt_ff == 32'(WINDOW_CYCLES - 1));
      nxt_win_cnt = window_end ? 32'h00000000 : win_cnt_ff + 32'h00000001;
      // a beat in the last cycle already counts toward the next window
      nxt_tx_acc  = window_end ? 32'h00000000 : tx_acc_ff;
      nxt_rx_acc  = window_end ? 32'h00000000 : rx_acc_ff;
      // (RULE11) transmit beat bytes
      if (TX_BEAT) begin
         nxt_tx_acc = sat_add(window_end ? 32'h00000000 : tx_acc_ff, TX_BEAT_BYTES);
      end
      // (RULE12) receive payload bytes
      if (RX_BEAT) begin
         nxt_rx_acc = sat_add(window_end ? 32'h00000000 : rx_acc_ff, RX_BEAT_BYTES);
      end
      nxt_tx_pub  = window_end ? tx_acc_ff[31:2] : tx_pub_ff;
      nxt_rx_pub  = window_end ? rx_acc_ff[31:2] : rx_pub_ff;
      // (RULE10) one shared sample count, wraps after four samples
      nxt_samples = window_end ? samples_ff + 2'h1 : samples_ff;
   end

   // (RULE3) counters start empty
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         win_cnt_ff <= 32'h00000000;
         tx_acc_ff  <= 32'h00000000;
         rx_acc_ff  <= 32'h00000000;
         tx_pub_ff  <= 30'h00000000;
         rx_pub_ff  <= 30'h00000000;
         samples_ff <= 2'h0;
      end else begin
         win_cnt_ff <= nxt_win_cnt;
         tx_acc_ff  <= nxt_tx_acc;
         rx_acc_ff  <= nxt_rx_acc;
         tx_pub_ff  <= nxt_tx_pub;
         rx_pub_ff  <= nxt_rx_pub;
         samples_ff <= nxt_samples;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // read port
   // registered answer costs a cycle but keeps the outputs glitch free
   always_comb begin
      // (RULE4) holes and idle cycles read zero
      nxt_rvalid = REG_RD;
      nxt_rdata  = 32'h00000000;
      if (REG_RD) begin
         // (RULE5) fixed offset decode
         case (REG_ADDR)
            // (RULE6) identification word, upper bits left zero
            OFS_IDENT:    nxt_rdata = {20'h00000, IDENT_VERSION, IDENT_VARIANT};
            // (RULE2) reserved status bits zero
            OFS_STATUS:   nxt_rdata = {26'h0000000, empty_ff, rst_n_ff, calib_ff};
            OFS_TX_COUNT: nxt_rdata = {tx_pub_ff, samples_ff};
            OFS_RX_COUNT: nxt_rdata = {rx_pub_ff, samples_ff};
            default:      nxt_rdata = 32'h00000000;
         endcase
      end
   end

   // (RULE3) nothing to answer after reset
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rdata_ff  <= 32'h00000000;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // outputs, each straight from its flip-flop
   // (RULE1) full-word read data
   assign REG_RDATA                  = rdata_ff;
   assign REG_RVALID                 = rvalid_ff;
   assign INTERCONNECT_MEMIF_RESET_N = rst_n_ff;
endmodule

/* include/dsp_pkg.sv */
// constants for the design status and throughput register bank
// What this block does
// (RULE1) every register is a full 32-bit word for host reads and writes
// (RULE2) unassigned bit positions are reserved and read back as zero
// (RULE3) reset puts every register at its default value
// (RULE4) reads of unimplemented offsets inside the bank return zero
// (RULE5) registers decode at fixed offsets in the first base address window
// (RULE6) identification word is read-only: variant bits 3:0, version bits 11:4
// (RULE7) status bit 0 reads one once memory calibration is done
// (RULE8) status bit 1 is active-low reset, defaults one, self-restores after 9 cycles
// (RULE9) status bits 5:2 show per-port buffers empty, reset value F
// (RULE10) counter bits 1:0 are a sample count bumped at each one-second sample
// (RULE11) transmit register bits 31:2 hold transmit beat bytes, 4-byte resolution
// (RULE12) receive register bits 31:2 hold receive payload bytes, 4-byte resolution
// (RULE13) counters accumulate one second, then publish and restart from zero
package dsp_pkg;
   localparam int          ADDR_W          = 16;
   localparam logic [15:0] OFS_IDENT       = 16'h9000;
   localparam logic [15:0] OFS_STATUS      = 16'h9008;
   localparam logic [15:0] OFS_TX_COUNT    = 16'h900C;
   localparam logic [15:0] OFS_RX_COUNT    = 16'h9010;
   localparam logic [15:0] BANK_BASE       = 16'h9000;
   localparam logic [15:0] BANK_LAST       = 16'h90FF;
   localparam logic [3:0]  IDENT_VARIANT   = 4'h1;
   localparam logic [7:0]  IDENT_VERSION   = 8'h10;
   localparam int          STS_CALIB_BIT   = 0;
   localparam int          STS_RESET_BIT   = 1;
   localparam int          STS_EMPTY_LSB   = 2;
   localparam int          NUM_PORTS       = 4;
   localparam logic [3:0]  EMPTY_RESET     = 4'hF;
   localparam int          RESET_HOLD_CYC  = 9;
   localparam int          CLK_HZ          = 25000000;
   localparam int          WINDOW_S        = 1;
   localparam int          WINDOW_CYC      = CLK_HZ * WINDOW_S;
   localparam int          SAMPLE_W        = 2;
   localparam int          BYTES_PER_UNIT  = 4;
endpackage

/* test/dsp_regs_assertions.sv */
// port-level checks for the register bank
`timescale 1ns/1ps
module dsp_regs_checker (
   input logic        CORE_CLK,
   input logic        RSTN,
   input logic [15:0] REG_ADDR,
   input logic        REG_WR,
   input logic        REG_RD,
   input logic [31:0] REG_WDATA,
   input logic [31:0] REG_RDATA,
   input logic        REG_RVALID,
   input logic        INTERCONNECT_MEMIF_RESET_N
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   read_answer_a: assert property (REG_RD |=> REG_RVALID)
      else $error("read not answered next cycle");
   answer_cause_a: assert property (REG_RVALID |-> $past(REG_RD))
      else $error("read valid without a read");
   idle_data_a: assert property (!REG_RVALID |-> REG_RDATA == 32'h0)
      else $error("read data not zero when idle");
   ident_word_a: assert property (REG_RD && REG_ADDR == 16'h9000 |=> REG_RDATA == 32'h101)
      else $error("identification word wrong");
   hole_zero_a: assert property (REG_RD && REG_ADDR == 16'h9004 |=> REG_RDATA == 32'h0)
      else $error("address hole not zero");
   status_rsvd_a: assert property (REG_RD && REG_ADDR == 16'h9008 |=> REG_RDATA[31:6] == 26'h0)
      else $error("status reserved bits set");
   reset_hold_a: assert property (REG_WR && REG_ADDR == 16'h9008 && !REG_WDATA[1]
      |=> !INTERCONNECT_MEMIF_RESET_N [*8] ##1 !INTERCONNECT_MEMIF_RESET_N)
      else $error("reset out not held low");
   reset_back_a: assert property ($fell(INTERCONNECT_MEMIF_RESET_N) |-> ##9 INTERCONNECT_MEMIF_RESET_N)
      else $error("reset out not restored");
   refused_wr_a: assert property (REG_WR && INTERCONNECT_MEMIF_RESET_N
      && (REG_ADDR != 16'h9008 || REG_WDATA[1]) |=> INTERCONNECT_MEMIF_RESET_N)
      else $error("ignored write moved reset out");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind dsp_regs dsp_regs_checker u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .REG_RVALID(REG_RVALID), .INTERCONNECT_MEMIF_RESET_N(INTERCONNECT_MEMIF_RESET_N));

/* test/tb_top.sv */
// self-checking bench for the register bank
`timescale 1ns/1ps
module tb_top;
   import dsp_pkg::*;
   localparam int WIN = 100;
   logic clk = 0, rstn = 0, wr = 0, rd = 0, calib = 0, txb = 0, rxb = 0;
   logic [15:0] addr = 16'h0;
   logic [31:0] wdata = 32'h0, rdata, got;
   logic [3:0]  empty = 4'hF;
   logic [7:0]  txn = 8'h0, rxn = 8'h0;
   logic [1:0]  s;
   logic        rvalid, rst_out_n;
   int          mismatches = 0, check_count = 0, n;
   always #20 clk = ~clk;
   dsp_regs #(.WINDOW_CYCLES(WIN)) u_dsp_regs (.CORE_CLK(clk), .RSTN(rstn), .REG_ADDR(addr),
      .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .CALIB_DONE(calib), .PORT_BUFFER_EMPTY_FLAGS(empty), .TX_BEAT(txb), .TX_BEAT_BYTES(txn),
      .RX_BEAT(rxb), .RX_BEAT_BYTES(rxn), .INTERCONNECT_MEMIF_RESET_N(rst_out_n));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd_reg(logic [15:0] a);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      // read data stands only in the cycle after the strobe
      got = rdata;
      rd = 1'b0;
      @(negedge clk);
   endtask
   task automatic check_rd(string what, logic [15:0] a, logic [31:0] exp);
      rd_reg(a);
      chk(what, got, exp);
   endtask
   task automatic wr_reg(logic [15:0] a, logic [31:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   // a full window of steady beats, low two bits dropped
   function automatic logic [31:0] exp_bytes(logic on, logic [7:0] b);
      return on ? (32'(WIN) * {24'h0, b}) & 32'hFFFFFFFC : 32'h0;
   endfunction
   task automatic give_verdict;
      if (mismatches == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(55980));
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      check_rd("ident", 16'h9000, 32'h00000101);
      check_rd("status", 16'h9008, 32'h0000003E);
      check_rd("tx count", 16'h900C, 32'h0);
      check_rd("rx count", 16'h9010, 32'h0);
      check_rd("hole", 16'h9004, 32'h0);
      check_rd("hole", 16'h90FC, 32'h0);
      wr_reg(16'h9000, 32'h0);
      wr_reg(16'h9004, 32'h0);
      check_rd("ident", 16'h9000, 32'h00000101);
      calib = 1'b1;
      empty = 4'($urandom());
      repeat (6) @(negedge clk);
      check_rd("status", 16'h9008, {26'h0, empty, 2'b11});
      wr_reg(16'h9008, 32'hFFFFFFFD);
      n = 0;
      repeat (20) begin
         n += int'(rst_out_n === 1'b0);
         @(negedge clk);
      end
      chk("reset cycles", n, 32'd9);
      wr_reg(16'h9008, 32'h00000002);
      check_rd("status", 16'h9008, {26'h0, empty, 2'b11});
      for (int i = 0; i < 3; i++) begin
         txn = 8'($urandom_range(8, 1));
         rxn = 8'($urandom_range(8, 1));
         txb = (i != 1);
         rxb = (i != 2);
         repeat (2 * WIN + 10) @(negedge clk);
         rd_reg(16'h900C);
         s = got[1:0];
         chk("tx bytes", {got[31:2], 2'b00}, exp_bytes(txb, txn));
         rd_reg(16'h9010);
         chk("rx bytes", {got[31:2], 2'b00}, exp_bytes(rxb, rxn));
         repeat (WIN - 6) @(negedge clk);
         rd_reg(16'h900C);
         chk("sample count", {30'h0, got[1:0]}, {30'h0, s + 2'd1});
         chk("tx bytes", {got[31:2], 2'b00}, exp_bytes(txb, txn));
      end
      give_verdict();
   end
   initial begin
      #(40 * 3000);
      mismatches++;
      give_verdict();
   end
endmodule
